// ==== src/fcsm_host.sv ====
// Purpose: host controller that drives an asynchronous parallel flash bus
// Assumes: APB slave for software; flash strobes are plain pins
// Notes:   one operation at a time; a start while busy is refused
`timescale 1ns/100ps
module fcsm_host (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output fcsm_pkg::fcsm_apb_rsp_t      apb_rsp,
  // flash side
  output fcsm_pkg::fcsm_pins_t         pins,
  input  wire logic [7:0]              dq_in,
  input  wire logic                    ready_busy_n
);
  import fcsm_pkg::*;

  typedef struct packed {
    fcsm_state_t   st;
    fcsm_op_t      op;
    logic [2:0]    idx;
    logic [8:0]    cnt;
    logic [20:0]   addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    logic          busy;
    logic          done;
    logic          refused;
    logic          asel;
    logic          timeout;
    fcsm_pins_t    pins;
    fcsm_apb_rsp_t rsp;
  } fcsm_regs_t;

  fcsm_regs_t cur_reg;
  fcsm_regs_t cur_next;
  logic [1:0] rst_sync_reg;
  logic       rst_int_n;
  logic [7:0] dq_s1_reg;
  logic [7:0] dq_s2_reg;
  logic       rb_s1_reg;
  logic       rb_s2_reg;

  // =====================================================================
  // command table
  function automatic logic [2:0] seq_len(input fcsm_op_t op);
    case (op)
      OP_RESET:      seq_len = 3'd1;
      OP_ASEL:       seq_len = 3'd3;
      OP_PROG:       seq_len = 3'd4;
      OP_CHIP_ERASE: seq_len = 3'd6;
      default:       seq_len = 3'd0;
    endcase
  endfunction

  // returns {address, data} of write cycle idx
  function automatic logic [28:0] seq_cycle(input fcsm_op_t op, input logic [2:0] idx,
                                            input logic [20:0] a, input logic [7:0] d);
    seq_cycle = {ADDR_UNLOCK1, CMD_UNLOCK1};
    if (op == OP_RESET) begin
      seq_cycle = {a, CMD_RESET};
    end else begin
      case (idx)
        3'd1, 3'd4: seq_cycle = {ADDR_UNLOCK2, CMD_UNLOCK2};
        3'd2: begin
          case (op)
            OP_ASEL: seq_cycle = {ADDR_UNLOCK1, CMD_ASEL};
            OP_PROG: seq_cycle = {ADDR_UNLOCK1, CMD_PROG};
            default: seq_cycle = {ADDR_UNLOCK1, CMD_ERASE};
          endcase
        end
        3'd3: seq_cycle = (op == OP_PROG) ? {a, d} : {ADDR_UNLOCK1, CMD_UNLOCK1};
        3'd5: seq_cycle = {ADDR_UNLOCK1, CMD_CHIP};
        default: seq_cycle = {ADDR_UNLOCK1, CMD_UNLOCK1};
      endcase
    end
  endfunction

  // =====================================================================
  // reset release and pin synchronisers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_reg[1];

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
      rb_s1_reg <= ready_busy_n;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // =====================================================================
  // next state
  always_comb begin
    logic        acc;
    logic        wr_go;
    logic        start;
    logic [28:0] cyc;
    logic [31:0] rd;
    cur_next = cur_reg;
    acc      = psel && penable && !cur_reg.rsp.pready;
    wr_go    = psel && penable && pwrite && cur_reg.rsp.pready;
    start    = 1'b0;
    rd       = 32'h0000_0000;
    cyc      = seq_cycle(cur_reg.op, cur_reg.idx, cur_reg.addr, cur_reg.wdata);

    // one wait state on every access; answer and data come from flops
    cur_next.rsp.pready  = acc;
    cur_next.rsp.pslverr = 1'b0;
    if (acc && !pwrite) begin
      case (paddr)
        REG_CTRL:   rd = {29'h0, cur_reg.op};
        REG_ADDR:   rd = {11'h000, cur_reg.addr};
        REG_WDATA:  rd = {24'h00_0000, cur_reg.wdata};
        REG_STATUS: rd = {26'h000_0000, cur_reg.timeout, cur_reg.asel, rb_s2_reg,
                          cur_reg.refused, cur_reg.done, cur_reg.busy};
        REG_RDATA:  rd = {24'h00_0000, cur_reg.rdata};
        default:    rd = 32'h0000_0000;
      endcase
      cur_next.rsp.prdata = rd;
    end
    if (wr_go) begin
      case (paddr)
        REG_CTRL: begin
          if (cur_reg.busy) begin
            cur_next.refused = 1'b1;
          end else begin
            cur_next.op = fcsm_op_t'(pwdata[2:0]);
            start       = 1'b1;
          end
        end
        REG_ADDR:  if (!cur_reg.busy) cur_next.addr = pwdata[20:0];
        REG_WDATA: if (!cur_reg.busy) cur_next.wdata = pwdata[7:0];
        REG_STATUS: begin
          if (pwdata[ST_DONE])    cur_next.done = 1'b0;
          if (pwdata[ST_REFUSED]) cur_next.refused = 1'b0;
          if (pwdata[ST_TIMEOUT]) cur_next.timeout = 1'b0;
        end
        default: ;
      endcase
    end

    if (cur_reg.cnt != 9'd0) begin
      cur_next.cnt = cur_reg.cnt - 9'd1;
    end

    case (cur_reg.st)
      S_IDLE: begin
        // idle bus: strobes high so no write state exists at power-up
        cur_next.pins.ce_n  = 1'b1;
        cur_next.pins.we_n  = 1'b1;
        cur_next.pins.oe_n  = 1'b1;
        cur_next.pins.dq_oe = 1'b0;
        if (start) begin
          cur_next.busy = 1'b1;
          cur_next.idx  = 3'd0;
          case (fcsm_op_t'(pwdata[2:0]))
            OP_READ: begin
              cur_next.pins.addr = cur_reg.addr;
              cur_next.pins.ce_n = 1'b0;
              cur_next.pins.oe_n = 1'b0;
              cur_next.cnt       = 9'(ACC_CYC);
              cur_next.st        = S_RACC;
            end
            OP_HW_RESET: begin
              cur_next.pins.rst_pin_n = 1'b0;
              cur_next.cnt            = 9'(HWRST_CYC);
              cur_next.st             = S_HWRST;
            end
            OP_RESET, OP_ASEL, OP_PROG, OP_CHIP_ERASE: begin
              cur_next.st = S_SETUP;
            end
            default: begin
              cur_next.busy    = 1'b0;
              cur_next.refused = 1'b1;
            end
          endcase
        end
      end
      S_SETUP: begin
        // address and data settle with output enable high, then strobes fall
        cur_next.pins.oe_n   = 1'b1;
        cur_next.pins.addr   = cyc[28:8];
        cur_next.pins.dq_out = cyc[7:0];
        cur_next.pins.dq_oe  = 1'b1;
        if (cur_reg.cnt == 9'd0 && cur_reg.pins.dq_oe) begin
          // both strobes fall together: address caught on that edge
          cur_next.pins.ce_n = 1'b0;
          cur_next.pins.we_n = 1'b0;
          cur_next.cnt       = 9'(WE_LOW_CYC);
          cur_next.st        = S_WLOW;
        end else if (!cur_reg.pins.dq_oe) begin
          cur_next.cnt = 9'(SETUP_CYC);
        end
      end
      S_WLOW: begin
        // low pulse far wider than any glitch the device rejects
        if (cur_reg.cnt == 9'd0) begin
          cur_next.pins.we_n = 1'b1;
          cur_next.pins.ce_n = 1'b1;
          cur_next.cnt       = 9'(WE_HIGH_CYC);
          cur_next.st        = S_WHIGH;
        end
      end
      S_WHIGH: begin
        // data held through the high time so the rising edge catches it
        if (cur_reg.cnt == 9'd0) begin
          cur_next.pins.dq_oe = 1'b0;
          if (cur_reg.idx == seq_len(cur_reg.op) - 3'd1) begin
            cur_next.asel = (cur_reg.op == OP_ASEL);
            if (cur_reg.op == OP_PROG || cur_reg.op == OP_CHIP_ERASE) begin
              cur_next.cnt = 9'(BUSY_CYC);
              cur_next.st  = S_BUSY;
            end else begin
              cur_next.busy = 1'b0;
              cur_next.done = 1'b1;
              cur_next.st   = S_IDLE;
            end
          end else begin
            cur_next.idx = cur_reg.idx + 3'd1;
            cur_next.st  = S_SETUP;
          end
        end
      end
      S_RACC: begin
        if (cur_reg.cnt == 9'd0) begin
          cur_next.rdata     = dq_s2_reg;
          cur_next.pins.ce_n = 1'b1;
          cur_next.pins.oe_n = 1'b1;
          cur_next.busy      = 1'b0;
          cur_next.done      = 1'b1;
          cur_next.st        = S_IDLE;
        end
      end
      S_BUSY: begin
        // commands would be ignored now, so none are sent until ready
        if (cur_reg.cnt == 9'd0 && cur_reg.pins.oe_n) begin
          // open a status read; dq is junk until the access time passes
          cur_next.pins.addr = cur_reg.addr;
          cur_next.pins.ce_n = 1'b0;
          cur_next.pins.oe_n = 1'b0;
          cur_next.cnt       = 9'(ACC_CYC);
        end else if (cur_reg.cnt == 9'd0 && rb_s2_reg) begin
          cur_next.cnt = 9'(ACC_CYC);
          cur_next.op  = OP_READ;
          cur_next.st  = S_RACC;
        end else if (cur_reg.cnt == 9'd0 && dq_s2_reg[TIMEOUT_BIT]) begin
          // sticky until software writes the ST_TIMEOUT bit of the status register
          cur_next.timeout = 1'b1;
        end
      end
      S_HWRST: begin
        if (cur_reg.cnt == 9'd0) begin
          cur_next.pins.rst_pin_n = 1'b1;
          cur_next.cnt            = 9'(HWRST_CYC);
          cur_next.st             = S_HWREC;
        end
      end
      S_HWREC: begin
        if (cur_reg.cnt == 9'd0) begin
          cur_next.asel = 1'b0;
          cur_next.busy = 1'b0;
          cur_next.done = 1'b1;
          cur_next.st   = S_IDLE;
        end
      end
      default: cur_next.st = S_IDLE;
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cur_reg                <= '0;
      cur_reg.st             <= S_IDLE;
      cur_reg.op             <= OP_READ;
      cur_reg.pins.ce_n      <= 1'b1;
      cur_reg.pins.we_n      <= 1'b1;
      cur_reg.pins.oe_n      <= 1'b1;
      cur_reg.pins.rst_pin_n <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign apb_rsp = cur_reg.rsp;
  assign pins    = cur_reg.pins;

endmodule

// ==== include/fcsm_pkg.sv ====
// Purpose: constants and carrier types for the flash command host controller
// Assumes: 250 MHz core clock, 8-bit flash data bus, 21-bit flash address
// Notes:   register offsets are byte addresses of aligned 32-bit words
//
// Summary of operation
// - write cycle only while chip select and write low, output enable high.
// - host must issue reset after timeout_flag high or in autoselect.
// - byte program is two unlocks, set-up, then address and data.
// - chip erase is unlock pair, set-up, unlock pair, chip erase command.
package fcsm_pkg;

  localparam int CLK_MHZ = 250;

  // =====================================================================
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_READY   = 3;
  localparam int ST_ASEL    = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int TIMEOUT_BIT = 5;

  // =====================================================================
  // command codes and addresses
  localparam logic [20:0] ADDR_UNLOCK1 = 21'h000555;
  localparam logic [20:0] ADDR_UNLOCK2 = 21'h0002aa;
  localparam logic [7:0]  CMD_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_ASEL     = 8'h90;
  localparam logic [7:0]  CMD_PROG     = 8'ha0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;

  // =====================================================================
  // timing
  localparam int T_WE_LOW_NS  = 40;
  localparam int T_WE_HIGH_NS = 20;
  localparam int T_SETUP_NS   = 8;
  localparam int T_ACC_NS     = 70;
  localparam int T_HWRST_NS   = 500;
  localparam int T_BUSY_NS    = 90;
  localparam int SYNC_LAT     = 2;
  localparam int WE_LOW_CYC   = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_HIGH_CYC  = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;
  localparam int HWRST_CYC    = (T_HWRST_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_CYC     = (T_BUSY_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;

  typedef enum logic [2:0] {
    OP_READ, OP_RESET, OP_ASEL, OP_PROG, OP_CHIP_ERASE, OP_HW_RESET
  } fcsm_op_t;

  typedef enum {
    S_IDLE, S_SETUP, S_WLOW, S_WHIGH, S_RACC, S_BUSY, S_HWRST, S_HWREC
  } fcsm_state_t;

  // flash pins, all driven from flops
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        rst_pin_n;
    logic [20:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } fcsm_pins_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fcsm_apb_rsp_t;

endpackage

// ==== sim/fcsm_flash_model.sv ====
// Purpose: behavioural flash device on the far side of the host controller
// Assumes: no clock; write cycles seen on strobe levels only
// Notes:   codes are arbitrary; bits only clear when programmed
`timescale 1ns/100ps
module fcsm_flash_model
  import fcsm_pkg::*;
#(
  parameter int         PROG_NS     = 300,
  parameter int         ERASE_NS    = 2000,
  parameter logic [7:0] MAKER_CODE  = 8'h5a, // arbitrary
  parameter logic [7:0] DEVICE_CODE = 8'hc3  // arbitrary
) (
  // flash bus
  input  fcsm_pkg::fcsm_pins_t pins,
  output logic [7:0]           dq_in,
  output logic                 ready_busy_n
);
  logic [7:0]  mem [logic [20:0]];
  logic [20:0] a_lat;
  // supply taken as above the lockout threshold from time zero
  logic        busy = 0, asel = 0, tmo = 0, ers = 0;
  int          step = 0, job = 0;
  realtime     t_fall = -1;
  wire         wr = !pins.ce_n && !pins.we_n && pins.oe_n;

  // =====================================================================
  // command decoding
  // no erase suspend here: a chip erase runs to its end unless rst_pin_n falls
  task automatic go(input int ns);
    int id;
    busy = 1;
    id = ++job;
    fork
      begin
        #(ns);
        if (id == job) busy = 0;
      end
    join_none
  endtask

  task automatic cmd(input logic [20:0] a, input logic [7:0] d);
    logic [7:0] old;
    if (busy) return;
    if (d == CMD_RESET && step != 3) begin
      {step, ers, asel, tmo} = '0;
      return;
    end
    if (asel) return;
    case (step)
      0: step = (a == ADDR_UNLOCK1 && d == CMD_UNLOCK1) ? 1 : 0;
      1: step = (a == ADDR_UNLOCK2 && d == CMD_UNLOCK2) ? 2 : 0;
      2: begin
        step = (a == ADDR_UNLOCK1 && !ers && d == CMD_PROG) ? 3 : 0;
        if (a == ADDR_UNLOCK1 && ers && d == CMD_CHIP) begin
          mem.delete();
          go(ERASE_NS);
        end
        asel = (a == ADDR_UNLOCK1 && !ers && d == CMD_ASEL);
        ers = (a == ADDR_UNLOCK1 && !ers && d == CMD_ERASE);
        return;
      end
      default: begin
        old = mem.exists(a) ? mem[a] : 8'hff;
        tmo = |(d & ~old);
        mem[a] = old & d;
        step = 0;
        go(PROG_NS);
      end
    endcase
    if (step == 0) ers = 0;
  endtask

  // strobe levels at time zero never arm a write
  always @(posedge wr) begin
    a_lat = pins.addr;
    t_fall = ($realtime > 0) ? $realtime : -1;
  end

  always @(negedge wr) begin
    if (t_fall >= 0 && $realtime - t_fall >= 5.0) cmd(a_lat, pins.dq_out);
  end

  always @(negedge pins.rst_pin_n) begin
    {step, ers, asel, tmo, busy} = '0;
    job++;
  end

  // =====================================================================
  // read path
  function automatic logic [7:0] rd_val(input logic [20:0] a);
    if (busy || tmo) return {2'b00, tmo, 5'h00};
    if (asel && a[7:0] == 8'h00) return MAKER_CODE;
    if (asel && a[7:0] == 8'h01) return DEVICE_CODE;
    if (asel && a[7:0] == 8'h02) return 8'h00;
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  // deselected bus shows the inverse so a stale value never passes
  // transport delay, and state changes re-drive the bus as well as pin changes
  always @(pins, busy, tmo, asel) begin
    dq_in <= #40 (!pins.ce_n && !pins.oe_n) ? rd_val(pins.addr) : ~rd_val(pins.addr);
  end
  assign ready_busy_n = !busy;
endmodule

// ==== sim/fcsm_host_monitor.sv ====
// Purpose: port checker for the flash host controller
// Assumes: single clock domain
// Notes:   attached by bind at the foot
`timescale 1ns/100ps
module fcsm_host_monitor (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input fcsm_pkg::fcsm_apb_rsp_t apb_rsp,
  // flash
  input fcsm_pkg::fcsm_pins_t   pins
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_we_low;  !pins.we_n [*8]; endsequence
  sequence s_we_gap;  pins.we_n [*4]; endsequence

  property p_write_gate; !pins.we_n |-> pins.oe_n && !pins.ce_n; endproperty
  property p_no_glitch; $fell(pins.we_n) |-> s_we_low; endproperty
  property p_we_gap; $rose(pins.we_n) |-> s_we_gap; endproperty
  property p_cycle_hold;
    !pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out);
  endproperty
  property p_data_drive; !pins.we_n |-> pins.dq_oe; endproperty
  property p_no_fight; !pins.oe_n |-> !pins.dq_oe; endproperty
  property p_hw_pulse; $fell(pins.rst_pin_n) |-> !pins.rst_pin_n [*8]; endproperty
  property p_apb_answer; psel && penable && !apb_rsp.pready |=> apb_rsp.pready; endproperty
  property p_pready_pulse; apb_rsp.pready |=> !apb_rsp.pready && !apb_rsp.pslverr; endproperty

  a_write_gate: assert property (p_write_gate) else $error("write strobe outside write gate");
  a_no_glitch: assert property (p_no_glitch) else $error("write strobe pulse too short");
  a_we_gap: assert property (p_we_gap) else $error("write cycles too close");
  a_cycle_hold: assert property (p_cycle_hold) else $error("addr or data moved in cycle");
  a_data_drive: assert property (p_data_drive) else $error("data not driven in write");
  a_no_fight: assert property (p_no_fight) else $error("host drives data during read");
  a_hw_pulse: assert property (p_hw_pulse) else $error("hardware reset pulse short");
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long or error");
endmodule

bind fcsm_host fcsm_host_monitor mon_u (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .apb_rsp(apb_rsp), .pins(pins)
);

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model on the far side; apb master tasks
// Notes:   shadow array mirrors what the flash should hold
`timescale 1ns/100ps
module tb_top;
  import fcsm_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a, DEVICE = 8'hc3; // arbitrary
  logic          core_clk = 0, rst_n, psel, penable, pwrite, ready_busy_n;
  logic [7:0]    paddr, dq_in, d;
  logic [31:0]   pwdata, rd, stat;
  logic [20:0]   a;
  fcsm_apb_rsp_t apb_rsp;
  fcsm_pins_t    pins;
  logic [7:0]    sh [logic [20:0]];
  int            miscompares = 0, checks_done = 0, seed;

  fcsm_host dut_u (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .apb_rsp,
                   .pins, .dq_in, .ready_busy_n);
  fcsm_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash_u (.pins, .dq_in,
                   .ready_busy_n);

  always #2 core_clk = ~core_clk;

  // =====================================================================
  // helpers
  function automatic logic [7:0] arr_exp(input logic [20:0] x);
    return sh.exists(x) ? sh[x] : 8'hff;
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin @(posedge core_clk); end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    {psel, penable} <= 2'b00;
  endtask

  // poke issues a second start while busy, which must be refused
  task automatic op(input logic [2:0] c, input logic [20:0] x, input logic [7:0] v,
                    input bit poke = 0);
    int n = 0;
    apb(1, REG_ADDR, {11'h0, x});
    apb(1, REG_WDATA, {24'h0, v});
    apb(1, REG_CTRL, {29'h0, c});
    if (poke) apb(1, REG_CTRL, 32'h0);
    do begin apb(0, REG_STATUS, 0); n++; end while (rd[ST_DONE] !== 1'b1 && n < 400);
    stat = rd;
    chk(stat & 32'h3, 32'h2, "op done");
    apb(1, REG_STATUS, 32'h26);
  endtask

  task automatic rd_chk(input logic [20:0] x, input logic [7:0] e);
    op(OP_READ, x, 8'h00);
    apb(0, REG_RDATA, 0);
    chk(rd, {24'h0, e}, "read data");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  // =====================================================================
  // tests
  initial begin
    seed = 86810;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(0, REG_STATUS, 0); chk(rd, 32'h8, "status after reset");
    apb(0, 8'h14, 0); chk(rd, 32'h0, "unmapped read");
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) begin
      a = (i == 4) ? 21'h1fffff : 21'($random(seed));
      d = 8'($random(seed)) & 8'h7f;
      op(OP_PROG, a, d); sh[a] = d;
      chk(stat & 32'h20, 32'h0, "program flag");
      rd_chk(a, arr_exp(a));
    end
    d = 8'($random(seed)) & arr_exp(a);
    op(OP_PROG, a, d); sh[a] = sh[a] & d;
    chk(stat & 32'h20, 32'h0, "clear-only program flag");
    rd_chk(a, arr_exp(a));
    op(OP_PROG, a, 8'hff); chk(stat & 32'h20, 32'h20, "timeout flag");
    op(OP_RESET, 21'($random(seed)), 8'h00); rd_chk(a, arr_exp(a));
    $display("test program done");
    op(OP_ASEL, 21'h0, 8'h00);
    apb(0, REG_STATUS, 0); chk(rd & 32'h10, 32'h10, "autoselect mode");
    for (int k = 0; k < 6; k++) begin
      a = {13'($random(seed)), 8'(k % 3)};
      rd_chk(a, (k % 3 == 0) ? MAKER : (k % 3 == 1) ? DEVICE : 8'h00);
    end
    op(OP_RESET, 21'($random(seed)), 8'h00);
    apb(0, REG_STATUS, 0); chk(rd & 32'h10, 32'h0, "autoselect left");
    rd_chk(a, arr_exp(a));
    $display("test autoselect done");
    a = sh.first(a) ? a : 21'h0;
    op(OP_CHIP_ERASE, 21'h0, 8'h00, 1); chk(stat & 32'h4, 32'h4, "start refused");
    sh.delete();
    rd_chk(a, arr_exp(a));
    op(OP_HW_RESET, 21'h0, 8'h00); rd_chk(a, arr_exp(a));
    apb(1, REG_CTRL, 32'h6); apb(0, REG_STATUS, 0); chk(rd & 32'h4, 32'h4, "bad op code");
    $display("test erase_refuse done");
    conclude();
  end
endmodule
